// file: core/rse_exec.sv
// execute stage for rotate, subtracts, saturation and handler return
//
// The register addresses and the APB slave port were decided locally.
`timescale 1ns/1ps
`include "rse_regs.svh"
module rse_exec (
   input wire logic clk,
   input wire logic rst_b,
   input wire rse_pkg::rse_issue_t iss,
   output rse_pkg::rse_result_t res_r,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata_r,
   output logic pready_r,
   output logic pslverr_r,
   output logic irq_r
);
   logic [`RSE_SW_W-1:0] stat_r, loStat_r, hiStat_r, erStat_r;
   logic [31:0] bta_r, pc_r, loLink_r, hiLink_r;
   logic [31:0] loBta_r, hiBta_r, exception_return_address_r, exception_saved_branch_target_r;
   logic [`RSE_EV_W-1:0] events_r, mask_r, evSet;
   logic [31:0] s1, s2, subA, subB, outData, rdMux;
   logic [32:0] diff;
   logic [`RSE_SW_W-1:0] statNxt, rSt;
   logic [31:0] rPc, rBta;
   logic cFlag, userMode, isRet, doOp, retOk, retBad, jlk, statUpd;
   logic satLow, satHigh, satHit, subOvf, apbAcc, apbWr, hit;

   assign s1 = iss.src1;
   assign s2 = iss.src2;
   assign cFlag = stat_r[`RSE_B_C];
   assign userMode = stat_r[`RSE_B_USR];
   assign apbAcc = psel && penable && pready_r;
   assign apbWr = apbAcc && pwrite;

   ////////////////////////////////////////////////////////////////////
   // operand path
   always_comb begin
      isRet = iss.valid && (iss.word == `RSE_INTERRUPT_EXCEPTION_RETURN_WORD);
      doOp = iss.valid && iss.ccTrue && !isRet;
      retOk = isRet && !userMode;
      retBad = isRet && userMode;
      jlk = doOp && iss.op == rse_pkg::RSE_JLK && iss.flagSet;
      subA = s1;
      subB = s2;
      if (iss.op == rse_pkg::RSE_RSB) begin
         subA = s2;
         subB = s1;
      end
      diff = {1'b0, subA} - {1'b0, subB};
      if (iss.op == rse_pkg::RSE_SBW) begin
         diff = diff - {32'h00000000, cFlag};
      end
      subOvf = (subA[31] != subB[31]) && (diff[31] != subA[31]);
      satLow = $signed(s1) < $signed(`RSE_SAT_LO);
      satHigh = $signed(s1) > $signed(`RSE_SAT_HI);
      satHit = satLow || satHigh;
      case (iss.op)
         rse_pkg::RSE_ROT: outData = {cFlag, s1[31:1]};
         rse_pkg::RSE_SAT: outData = satLow ? `RSE_SAT_LO :
            (satHigh ? `RSE_SAT_HI : s1);
         default: outData = diff[31:0];
      endcase
   end

   ////////////////////////////////////////////////////////////////////
   // return source selection
   always_comb begin
      if (jlk) begin
         rPc = s1;
         rSt = iss.highLevel ? hiStat_r : loStat_r;
         rBta = iss.highLevel ? hiBta_r : loBta_r;
      end else if (!stat_r[`RSE_B_AE] && stat_r[`RSE_B_A2]) begin
         rPc = hiLink_r;
         rSt = hiStat_r;
         rBta = hiBta_r;
      end else if (!stat_r[`RSE_B_AE] && stat_r[`RSE_B_A1]) begin
         rPc = loLink_r;
         rSt = loStat_r;
         rBta = loBta_r;
      end else begin
         rPc = exception_return_address_r;
         rSt = erStat_r;
         rBta = exception_saved_branch_target_r;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // next status word
   always_comb begin
      statNxt = stat_r;
      statUpd = 1'b0;
      if (retOk || jlk) begin
         statUpd = 1'b1;
         statNxt = rSt;
         if (retOk) begin
            statNxt[`RSE_B_USR] = 1'b1;
            statNxt[`RSE_B_AE] = 1'b0;
         end
      end else if (doOp && iss.flagSet && iss.op != rse_pkg::RSE_JLK) begin
         statUpd = 1'b1;
         statNxt[`RSE_B_Z] = outData == 32'h00000000;
         statNxt[`RSE_B_N] = outData[31];
         case (iss.op)
            rse_pkg::RSE_ROT: statNxt[`RSE_B_C] = s1[0];
            rse_pkg::RSE_SAT: begin
               statNxt[`RSE_B_V] = satHit;
               statNxt[`RSE_B_S] = stat_r[`RSE_B_S] | satHit;
            end
            default: begin
               statNxt[`RSE_B_C] = diff[32];
               statNxt[`RSE_B_V] = subOvf;
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////
   // status word and branch target
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         stat_r <= `RSE_SW_RST;
      end else if (statUpd) begin
         stat_r <= statNxt;
      end else if (apbWr && paddr == `RSE_OFF_STAT) begin
         stat_r <= pwdata[`RSE_SW_W-1:0];
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         bta_r <= 32'h00000000;
         pc_r <= 32'h00000000;
      end else if (retOk || jlk) begin
         bta_r <= rBta;
         pc_r <= rPc;
      end else if (apbWr && paddr == `RSE_OFF_BTA) begin
         bta_r <= pwdata;
      end else if (apbWr && paddr == `RSE_OFF_PC) begin
         pc_r <= pwdata;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // saved state, loaded by software
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         loLink_r <= 32'h00000000;
         hiLink_r <= 32'h00000000;
         loStat_r <= `RSE_SW_RST;
         hiStat_r <= `RSE_SW_RST;
         loBta_r <= 32'h00000000;
         hiBta_r <= 32'h00000000;
         exception_return_address_r <= 32'h00000000;
         erStat_r <= `RSE_SW_RST;
         exception_saved_branch_target_r <= 32'h00000000;
         mask_r <= 3'h0;
      end else if (apbWr) begin
         if (paddr == `RSE_OFF_LOLINK) begin
            loLink_r <= pwdata;
         end else if (paddr == `RSE_OFF_HILINK) begin
            hiLink_r <= pwdata;
         end else if (paddr == `RSE_OFF_LOSTAT) begin
            loStat_r <= pwdata[`RSE_SW_W-1:0];
         end else if (paddr == `RSE_OFF_HISTAT) begin
            hiStat_r <= pwdata[`RSE_SW_W-1:0];
         end else if (paddr == `RSE_OFF_LOBTA) begin
            loBta_r <= pwdata;
         end else if (paddr == `RSE_OFF_HIBTA) begin
            hiBta_r <= pwdata;
         end else if (paddr == `RSE_OFF_EXCEPTION_RETURN_ADDRESS) begin
            exception_return_address_r <= pwdata;
         end else if (paddr == `RSE_OFF_ERSTAT) begin
            erStat_r <= pwdata[`RSE_SW_W-1:0];
         end else if (paddr == `RSE_OFF_EXCEPTION_SAVED_BRANCH_TARGET) begin
            exception_saved_branch_target_r <= pwdata;
         end else if (paddr == `RSE_OFF_MASK) begin
            mask_r <= pwdata[`RSE_EV_W-1:0];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////
   // result towards register file and fetch
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         res_r <= '0;
      end else begin
         res_r.valid <= iss.valid;
         res_r.we <= doOp && iss.hasDest && iss.op != rse_pkg::RSE_JLK;
         res_r.destIdx <= iss.destIdx;
         res_r.data <= outData;
         res_r.redirect <= retOk || jlk;
         res_r.newPc <= rPc;
         res_r.branchPend <= (retOk || jlk) && rSt[`RSE_B_DE];
         res_r.branchTgt <= rBta;
         res_r.privExc <= retBad;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // sticky events, cleared by reading, set wins
   always_comb begin
      evSet = '0;
      evSet[`RSE_EV_PRIV] = retBad;
      evSet[`RSE_EV_SAT] = doOp && iss.op == rse_pkg::RSE_SAT && satHit;
      evSet[`RSE_EV_RET] = retOk;
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         events_r <= '0;
         irq_r <= 1'b0;
      end else begin
         if (apbAcc && !pwrite && paddr == `RSE_OFF_EVENT) begin
            events_r <= evSet;
         end else begin
            events_r <= events_r | evSet;
         end
         irq_r <= |(events_r & mask_r);
      end
   end

   ////////////////////////////////////////////////////////////////////
   // apb read decode
   always_comb begin
      hit = 1'b1;
      rdMux = 32'h00000000;
      if (paddr == `RSE_OFF_STAT) begin
         rdMux[`RSE_SW_W-1:0] = stat_r;
      end else if (paddr == `RSE_OFF_BTA) begin
         rdMux = bta_r;
      end else if (paddr == `RSE_OFF_PC) begin
         rdMux = pc_r;
      end else if (paddr == `RSE_OFF_LOLINK) begin
         rdMux = loLink_r;
      end else if (paddr == `RSE_OFF_HILINK) begin
         rdMux = hiLink_r;
      end else if (paddr == `RSE_OFF_LOSTAT) begin
         rdMux[`RSE_SW_W-1:0] = loStat_r;
      end else if (paddr == `RSE_OFF_HISTAT) begin
         rdMux[`RSE_SW_W-1:0] = hiStat_r;
      end else if (paddr == `RSE_OFF_LOBTA) begin
         rdMux = loBta_r;
      end else if (paddr == `RSE_OFF_HIBTA) begin
         rdMux = hiBta_r;
      end else if (paddr == `RSE_OFF_EXCEPTION_RETURN_ADDRESS) begin
         rdMux = exception_return_address_r;
      end else if (paddr == `RSE_OFF_ERSTAT) begin
         rdMux[`RSE_SW_W-1:0] = erStat_r;
      end else if (paddr == `RSE_OFF_EXCEPTION_SAVED_BRANCH_TARGET) begin
         rdMux = exception_saved_branch_target_r;
      end else if (paddr == `RSE_OFF_EVENT) begin
         rdMux[`RSE_EV_W-1:0] = events_r;
      end else if (paddr == `RSE_OFF_MASK) begin
         rdMux[`RSE_EV_W-1:0] = mask_r;
      end else begin
         hit = 1'b0;
      end
   end

   // one wait state: ready in second access cycle
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         pready_r <= 1'b0;
         prdata_r <= 32'h00000000;
         pslverr_r <= 1'b0;
      end else begin
         pready_r <= psel && penable && !pready_r;
         prdata_r <= (psel && !pwrite) ? rdMux : 32'h00000000;
         pslverr_r <= psel && penable && !pready_r && !hit;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_b);

   logic isRot, isRsb, isSbw, isSat, flg, apbStat;
   assign isRot = doOp && iss.op == rse_pkg::RSE_ROT;
   assign isRsb = doOp && iss.op == rse_pkg::RSE_RSB;
   assign isSbw = doOp && iss.op == rse_pkg::RSE_SBW;
   assign isSat = doOp && iss.op == rse_pkg::RSE_SAT;
   assign flg = iss.flagSet;
   assign apbStat = apbWr && paddr == `RSE_OFF_STAT;

   sequence retIssued;
      isRet && !userMode;
   endsequence
   sequence retLands;
      res_r.redirect && stat_r[`RSE_B_USR] && !stat_r[`RSE_B_AE];
   endsequence

   chk_rot_carry_in: assert property (isRot |=>
      res_r.data[31] == $past(cFlag))
      else $error("rotate lost old carry");
   chk_flags_held: assert property (doOp && !flg && !apbStat |=>
      stat_r[3:0] == $past(stat_r[3:0]))
      else $error("flags moved without flag-set");
   chk_zero_neg: assert property ((isRot || isRsb) && flg |=>
      stat_r[`RSE_B_Z] == (res_r.data == 32'h00000000) &&
      stat_r[`RSE_B_N] == res_r.data[31])
      else $error("zero or negative flag wrong");
   chk_reverse_subtract_value: assert property (isRsb |=>
      res_r.data == $past(s2) - $past(s1))
      else $error("reverse subtract wrong");
   chk_reverse_subtract_borrow: assert property (isRsb && flg |=>
      stat_r[`RSE_B_C] == ($past(s2) < $past(s1)))
      else $error("reverse subtract borrow wrong");
   chk_ret_decode: assert property (retIssued |=> retLands)
      else $error("return not taken");
   chk_ret_priv: assert property (isRet && userMode |=>
      res_r.privExc && !res_r.redirect ##1 res_r.privExc == $past(retBad))
      else $error("user return not refused");
   chk_ret_exc: assert property (retIssued and stat_r[`RSE_B_AE] |=>
      res_r.newPc == $past(exception_return_address_r))
      else $error("exception return address wrong");
   chk_ret_high: assert property (retIssued and !stat_r[`RSE_B_AE]
      && stat_r[`RSE_B_A2] |=> res_r.newPc == $past(hiLink_r))
      else $error("high level return wrong");
   chk_ret_low: assert property (retIssued and !stat_r[`RSE_B_AE]
      && !stat_r[`RSE_B_A2] && stat_r[`RSE_B_A1] |=>
      res_r.newPc == $past(loLink_r))
      else $error("low level return wrong");
   chk_delay_pend: assert property (res_r.redirect |->
      res_r.branchPend == stat_r[`RSE_B_DE] && res_r.branchTgt == bta_r)
      else $error("pending branch not restored");
   chk_jump_target: assert property (jlk && iss.highLevel |=>
      bta_r == $past(hiBta_r))
      else $error("link jump target wrong");
   chk_sat_clamp: assert property (isSat && satHigh |=>
      res_r.data == `RSE_SAT_HI)
      else $error("saturate high clamp wrong");
   chk_sat_flags: assert property (isSat && flg && satHit |=>
      stat_r[`RSE_B_V] && stat_r[`RSE_B_S] &&
      stat_r[`RSE_B_C] == $past(cFlag))
      else $error("saturate flags wrong");
   chk_sbw_value: assert property (isSbw |=>
      res_r.data == $past(s1) - $past(s2) - {31'h0, $past(cFlag)})
      else $error("borrow subtract wrong");
   chk_sbw_borrow: assert property (isSbw && flg && !cFlag |=>
      stat_r[`RSE_B_C] == ($past(s1) < $past(s2)))
      else $error("borrow subtract carry wrong");
   chk_no_dest: assert property (iss.valid && !iss.hasDest |=>
      !res_r.we)
      else $error("write without destination");

endmodule // rse_exec

// file: inc/rse_regs.svh
// constants of the rotate, subtract, saturate and return execute block
`ifndef RSE_REGS_SVH
`define RSE_REGS_SVH
// register byte offsets
`define RSE_OFF_STAT 8'h00
`define RSE_OFF_BTA 8'h04
`define RSE_OFF_PC 8'h08
`define RSE_OFF_LOLINK 8'h0c
`define RSE_OFF_HILINK 8'h10
`define RSE_OFF_LOSTAT 8'h14
`define RSE_OFF_HISTAT 8'h18
`define RSE_OFF_LOBTA 8'h1c
`define RSE_OFF_HIBTA 8'h20
`define RSE_OFF_EXCEPTION_RETURN_ADDRESS 8'h24
`define RSE_OFF_ERSTAT 8'h28
`define RSE_OFF_EXCEPTION_SAVED_BRANCH_TARGET 8'h2c
`define RSE_OFF_EVENT 8'h30
`define RSE_OFF_MASK 8'h34
// status word fields
`define RSE_SW_W 12
`define RSE_B_Z 0
`define RSE_B_N 1
`define RSE_B_C 2
`define RSE_B_V 3
`define RSE_B_S 4
`define RSE_B_E1 5
`define RSE_B_E2 6
`define RSE_B_A1 7
`define RSE_B_A2 8
`define RSE_B_AE 9
`define RSE_B_DE 10
`define RSE_B_USR 11
`define RSE_SW_RST 12'h000
// event bits
`define RSE_EV_W 3
`define RSE_EV_PRIV 0
`define RSE_EV_SAT 1
`define RSE_EV_RET 2
// fixed words and bounds
`define RSE_INTERRUPT_EXCEPTION_RETURN_WORD 32'h246f003f
`define RSE_SAT_LO 32'hffff8000
`define RSE_SAT_HI 32'h00007fff
`endif

// file: inc/rse_pkg.sv
// types of the rotate, subtract, saturate and return execute block
package rse_pkg;
   typedef enum logic [5:0] {
      RSE_ROT = 6'b000001,
      RSE_RSB = 6'b000010,
      RSE_SBW = 6'b000100,
      RSE_SAT = 6'b001000,
      RSE_RET = 6'b010000,
      RSE_JLK = 6'b100000
   } rse_op_t;
   typedef struct packed {
      logic valid;
      rse_op_t op;
      logic [31:0] word;
      logic ccTrue;
      logic flagSet;
      logic hasDest;
      logic [5:0] destIdx;
      logic highLevel;
      logic [31:0] src1;
      logic [31:0] src2;
   } rse_issue_t;
   typedef struct packed {
      logic valid;
      logic we;
      logic [5:0] destIdx;
      logic [31:0] data;
      logic redirect;
      logic [31:0] newPc;
      logic branchPend;
      logic [31:0] branchTgt;
      logic privExc;
   } rse_result_t;
endpackage

// file: verif/rse_exec_tb.sv
// self-checking bench of the rotate, subtract, saturate and return block
`timescale 1ns/1ps
`include "rse_regs.svh"
module testbench;
   localparam rse_pkg::rse_op_t ROT = rse_pkg::RSE_ROT;
   localparam rse_pkg::rse_op_t RSB = rse_pkg::RSE_RSB;
   localparam rse_pkg::rse_op_t SBW = rse_pkg::RSE_SBW;
   localparam rse_pkg::rse_op_t SAT = rse_pkg::RSE_SAT;
   localparam rse_pkg::rse_op_t RET = rse_pkg::RSE_RET;
   localparam rse_pkg::rse_op_t JLK = rse_pkg::RSE_JLK;
   // one ordinary case: ctl is condition, flag-set, has destination
   typedef struct packed {
      rse_pkg::rse_op_t op;
      logic [31:0] s1;
      logic [31:0] s2;
      logic [2:0] ctl;
      logic [11:0] st;
      logic [31:0] d;
      logic [11:0] es;
   } rse_row_t;
   logic clk = 1'h0;
   logic rstB = 1'h0;
   rse_pkg::rse_issue_t iss = '0;
   rse_pkg::rse_result_t res;
   logic psel = 1'h0;
   logic penable = 1'h0;
   logic pwrite = 1'h0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic irq;
   logic [31:0] rd;
   logic err;
   int mismatches = 0;
   int numChecks = 0;
   rse_row_t rows [16];
   logic [31:0] setv [9] = '{32'h333, 32'h111, 32'h068, 32'h003, 32'h444,
      32'h222, 32'h100, 32'h465, 32'h200};

   rse_exec dut_u (
      .clk(clk),
      .rst_b(rstB),
      .iss(iss),
      .res_r(res),
      .psel(psel),
      .penable(penable),
      .pwrite(pwrite),
      .paddr(paddr),
      .pwdata(pwdata),
      .prdata_r(prdata),
      .pready_r(pready),
      .pslverr_r(pslverr),
      .irq_r(irq)
   );

   // core clock, 8 ns period
   initial begin
      forever #4 clk = ~clk;
   end

   ////////////////////////////////////////////////////////////////////////
   // counts and verdict
   task automatic wrapUp();
      $display("checks %0d mismatches %0d", numChecks, mismatches);
      if (mismatches == 0 && numChecks > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   // value compare
   task automatic chkV(input string nm, input logic [31:0] e,
         input logic [31:0] g);
      numChecks++;
      if (g !== e) begin
         mismatches++;
         $display("Error %s expected %h seen %h", nm, e, g);
      end
   endtask

   // one apb transfer, held until pready is seen high
   task automatic apb(input logic w, input logic [7:0] a,
         input logic [31:0] wd);
      int n = 0;
      @(posedge clk);
      psel <= 1'h1;
      pwrite <= w;
      paddr <= a;
      pwdata <= wd;
      @(posedge clk);
      penable <= 1'h1;
      // pready, read data and error are taken as sampled at the edge
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'h1 && n < 20);
      if (pready !== 1'h1) begin
         chkV("apb ready", 32'h1, {31'h0, pready});
         wrapUp();
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
   endtask

   // one instruction; result sampled after the answering edge
   task automatic issue(input rse_pkg::rse_op_t op, input logic [31:0] w,
         input logic [31:0] s1, input logic [31:0] s2,
         input logic [2:0] ctl, input logic hi);
      @(posedge clk);
      iss <= '{1'h1, op, w, ctl[2], ctl[1], ctl[0], 6'h05, hi, s1, s2};
      @(posedge clk);
      iss.valid <= 1'h0;
      #1;
   endtask

   // handler return from a given status word
   task automatic retCase(input logic [11:0] st, input logic [31:0] pc,
         input logic [11:0] es, input logic [31:0] branch_target_register, input logic pend);
      apb(1'h1, `RSE_OFF_STAT, {20'h0, st});
      issue(RET, `RSE_INTERRUPT_EXCEPTION_RETURN_WORD, 32'h0, 32'h0, 3'h4, 1'h0);
      chkV("redirect", 32'h1, {31'h0, res.redirect});
      chkV("new pc", pc, res.newPc);
      chkV("pending", {31'h0, pend}, {31'h0, res.branchPend});
      chkV("branch out", branch_target_register, res.branchTgt);
      chkV("valid", 32'h1, {31'h0, res.valid});
      apb(1'h0, `RSE_OFF_STAT, 32'h0);
      chkV("status", {20'h0, es}, rd);
      apb(1'h0, `RSE_OFF_BTA, 32'h0);
      chkV("target", branch_target_register, rd);
   endtask

   ////////////////////////////////////////////////////////////////////////
   // main sequence
   initial begin
      rows[0] = '{ROT, 32'h3, 32'h0, 3'h7, 12'h004, 32'h80000001, 12'h006};
      rows[1] = '{ROT, 32'h1, 32'h0, 3'h7, 12'h000, 32'h0, 12'h005};
      rows[2] = '{ROT, 32'h2, 32'h0, 3'h5, 12'h00c, 32'h80000001, 12'h00c};
      rows[3] = '{RSB, 32'h1, 32'h3, 3'h7, 12'h000, 32'h2, 12'h000};
      rows[4] = '{RSB, 32'h5, 32'h3, 3'h7, 12'h000, 32'hfffffffe, 12'h006};
      rows[5] = '{RSB, 32'h1, 32'h80000000, 3'h7, 12'h000, 32'h7fffffff,
         12'h008};
      rows[6] = '{SBW, 32'h5, 32'h2, 3'h7, 12'h004, 32'h2, 12'h000};
      rows[7] = '{SBW, 32'h0, 32'h0, 3'h7, 12'h004, 32'hffffffff, 12'h006};
      rows[8] = '{SBW, 32'h80000000, 32'h0, 3'h7, 12'h004, 32'h7fffffff,
         12'h008};
      rows[9] = '{SAT, 32'h8000, 32'h0, 3'h7, 12'h004, 32'h7fff, 12'h01c};
      rows[10] = '{SAT, 32'hffff7fff, 32'h0, 3'h7, 12'h000, 32'hffff8000,
         12'h01a};
      rows[11] = '{SAT, 32'hffff8000, 32'h0, 3'h7, 12'h010, 32'hffff8000,
         12'h012};
      rows[12] = '{SAT, 32'h7fff, 32'h0, 3'h7, 12'h008, 32'h7fff, 12'h000};
      rows[13] = '{RSB, 32'h2, 32'h2, 3'h6, 12'h000, 32'h0, 12'h001};
      rows[14] = '{RSB, 32'h1, 32'h3, 3'h3, 12'h00c, 32'h0, 12'h00c};
      rows[15] = '{SBW, 32'h5, 32'h2, 3'h7, 12'h000, 32'h3, 12'h000};
      repeat (6) @(posedge clk);
      chkV("reset result", 32'h0, {31'h0, |res});
      chkV("reset irq", 32'h0, {31'h0, irq});
      rstB <= 1'h1;
      apb(1'h0, `RSE_OFF_STAT, 32'h0);
      chkV("reset status", {20'h0, `RSE_SW_RST}, rd);
      chkV("mapped err", 32'h0, {31'h0, err});
      apb(1'h0, `RSE_OFF_MASK, 32'h0);
      chkV("reset mask", 32'h0, rd);
      // ordinary cases
      foreach (rows[i]) begin
         apb(1'h1, `RSE_OFF_STAT, {20'h0, rows[i].st});
         issue(rows[i].op, 32'h0, rows[i].s1, rows[i].s2, rows[i].ctl, 1'h0);
         chkV("write", {31'h0, rows[i].ctl[0] & rows[i].ctl[2]},
            {31'h0, res.we});
         chkV("dest idx", 32'h5, {26'h0, res.destIdx});
         if (rows[i].ctl[0] & rows[i].ctl[2]) begin
            chkV("data", rows[i].d, res.data);
         end
         apb(1'h0, `RSE_OFF_STAT, 32'h0);
         chkV("flags", {20'h0, rows[i].es}, rd);
      end
      // saved state registers written and read back
      for (int k = 0; k < 9; k++) begin
         apb(1'h1, `RSE_OFF_LOLINK + 8'(4 * k), setv[k]);
         apb(1'h0, `RSE_OFF_LOLINK + 8'(4 * k), 32'h0);
         chkV("saved reg", setv[k], rd);
      end
      apb(1'h0, `RSE_OFF_EVENT, 32'h0);
      chkV("sat events", 32'h2, rd);
      retCase(12'h300, 32'h100, 12'hc65, 32'h200, 1'h1);
      // second return now runs in user mode
      issue(RET, `RSE_INTERRUPT_EXCEPTION_RETURN_WORD, 32'h0, 32'h0, 3'h4, 1'h0);
      chkV("priv fault", 32'h1, {31'h0, res.privExc});
      chkV("no redirect", 32'h0, {31'h0, res.redirect});
      apb(1'h0, `RSE_OFF_STAT, 32'h0);
      chkV("user status", 32'hc65, rd);
      // masked, raised, cleared interrupt
      chkV("masked irq", 32'h0, {31'h0, irq});
      apb(1'h1, `RSE_OFF_MASK, 32'h1);
      repeat (2) @(posedge clk);
      #1;
      chkV("raised irq", 32'h1, {31'h0, irq});
      apb(1'h0, `RSE_OFF_EVENT, 32'h0);
      chkV("events", 32'h5, rd);
      repeat (2) @(posedge clk);
      #1;
      chkV("cleared irq", 32'h0, {31'h0, irq});
      apb(1'h0, `RSE_OFF_EVENT, 32'h0);
      chkV("events clear", 32'h0, rd);
      retCase(12'h180, 32'h111, 12'h803, 32'h222, 1'h0);
      retCase(12'h080, 32'h333, 12'h868, 32'h444, 1'h0);
      // word one bit off the return word
      apb(1'h1, `RSE_OFF_STAT, 32'h200);
      issue(RET, 32'h246f003e, 32'h0, 32'h0, 3'h4, 1'h0);
      chkV("near word", 32'h0, {31'h0, res.redirect});
      // flag jump through high level link
      apb(1'h1, `RSE_OFF_STAT, 32'h100);
      issue(JLK, 32'h0, 32'h500, 32'h0, 3'h6, 1'h1);
      chkV("jump pc", 32'h500, res.newPc);
      chkV("jump write", 32'h0, {31'h0, res.we});
      apb(1'h0, `RSE_OFF_BTA, 32'h0);
      chkV("jump target", 32'h222, rd);
      apb(1'h0, `RSE_OFF_STAT, 32'h0);
      chkV("jump status", 32'h003, rd);
      apb(1'h0, `RSE_OFF_PC, 32'h0);
      chkV("pc reg", 32'h500, rd);
      // flag jump through low level link
      apb(1'h1, `RSE_OFF_STAT, 32'h080);
      issue(JLK, 32'h0, 32'h600, 32'h0, 3'h6, 1'h0);
      chkV("low jump pc", 32'h600, res.newPc);
      apb(1'h0, `RSE_OFF_BTA, 32'h0);
      chkV("low jump target", 32'h444, rd);
      apb(1'h0, `RSE_OFF_STAT, 32'h0);
      chkV("low jump status", 32'h068, rd);
      // unmapped address
      apb(1'h0, 8'h40, 32'h0);
      chkV("unmapped err", 32'h1, {31'h0, err});
      chkV("unmapped data", 32'h0, rd);
      // reset in mid-run returns state to reset values
      rstB <= 1'h0;
      @(posedge clk);
      #1;
      chkV("mid reset result", 32'h0, {31'h0, |res});
      @(posedge clk);
      rstB <= 1'h1;
      apb(1'h0, `RSE_OFF_HIBTA, 32'h0);
      chkV("mid reset saved", 32'h0, rd);
      apb(1'h0, `RSE_OFF_STAT, 32'h0);
      chkV("mid reset status", {20'h0, `RSE_SW_RST}, rd);
      wrapUp();
   end
endmodule // testbench
